/* File: src/ceod_pkg.sv */
package ceod_pkg;

    // Instruction cycle is split into four phases
    localparam int          CEOD_PHASES     = 4;
    localparam logic [1:0]  CEOD_PH_RESET   = 2'h0;

    // Opcode prefixes
    localparam logic [6:0]  OP_TEST_SKIP    = 7'h33;     // 0110 011a
    localparam logic [7:0]  OP_XOR_LIT      = 8'h0A;     // 0000 1010
    localparam logic [5:0]  OP_XOR_FILE     = 6'h06;     // 0001 10da
    localparam logic [7:0]  OP_ADD_PTR      = 8'hE8;
    localparam logic [7:0]  OP_SUB_PTR      = 8'hE9;
    localparam logic [7:0]  OP_PUSH_LIT     = 8'hEA;
    localparam logic [7:0]  OP_INDEX_MOVE   = 8'hEB;
    localparam logic [15:0] OP_CALL_WORK    = 16'h0014;
    localparam logic [1:0]  PTR_SEL_RETURN  = 2'h3;
    localparam logic [1:0]  PTR_SEL_THIRD   = 2'h2;

    // Two-word instructions: 1100 xxxx and 1110 1011 through 1110 1111
    localparam logic [3:0]  TWO_WORD_PREFIX = 4'hC;
    localparam logic [7:0]  TWO_WORD_LOW    = 8'hEB;
    localparam logic [7:0]  TWO_WORD_HIGH   = 8'hEF;

    // Access bank and indexed literal offset layout
    localparam logic [7:0]  ILO_LIMIT       = 8'h5F;
    localparam logic [3:0]  ACCESS_LOW_PAGE = 4'h0;
    localparam logic [3:0]  ACCESS_SFR_PAGE = 4'hF;

    // Indirect register rows: addresses FD8..FEF, low three bits 3..7
    localparam logic [8:0]  IND_ROW_A       = 9'h1FB;
    localparam logic [8:0]  IND_ROW_B       = 9'h1FC;
    localparam logic [8:0]  IND_ROW_C       = 9'h1FD;
    localparam logic [2:0]  IND_LOW_MIN     = 3'h3;

    // Values after reset
    localparam logic        EXT_EN_RESET    = 1'b1;
    localparam logic [7:0]  WORK_RESET      = 8'h00;
    localparam logic [11:0] PTR_RESET       = 12'h000;
    localparam logic [20:0] RETURN_STEP     = 21'h000002;

    typedef enum logic [2:0] {
        ST_EXEC       = 3'b000,
        ST_SKIP_NOP   = 3'b001,
        ST_SKIP_NOP2  = 3'b010,
        ST_LAST_NOP   = 3'b011,
        ST_MOVE_WORD2 = 3'b100
    } ceod_state_t;

    typedef enum logic [3:0] {
        OPC_NONE      = 4'h0,
        OPC_TEST_SKIP = 4'h1,
        OPC_XOR_LIT   = 4'h2,
        OPC_XOR_FILE  = 4'h3,
        OPC_ADD_PTR   = 4'h4,
        OPC_SUB_PTR   = 4'h5,
        OPC_PUSH_LIT  = 4'h6,
        OPC_MOVE      = 4'h7,
        OPC_CALL_WORK = 4'h8
    } ceod_op_t;

    function automatic logic ceod_is_indirect(input logic [11:0] addr);
        logic [8:0] row;
        row = addr[11:3];
        return ((row == IND_ROW_A) || (row == IND_ROW_B) || (row == IND_ROW_C)) && (addr[2:0] >= IND_LOW_MIN);
    endfunction : ceod_is_indirect

    function automatic logic ceod_is_two_word(input logic [15:0] word);
        return (word[15:12] == TWO_WORD_PREFIX) || ((word[15:8] >= TWO_WORD_LOW) && (word[15:8] <= TWO_WORD_HIGH));
    endfunction : ceod_is_two_word

endpackage : ceod_pkg

/* File: src/ceod_phase_gen.sv */
`timescale 1ns/100ps
module ceod_phase_gen
    import ceod_pkg::*;
#(
    parameter int PHASES = CEOD_PHASES
)(
    input  wire logic clock,
    input  wire logic arst_n,
    output logic      ph_q1,
    output logic      ph_q2,
    output logic      ph_q3,
    output logic      ph_q4
);
    logic [1:0] phase_r;

    // Free-running quarter counter; one enable per phase
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            phase_r <= CEOD_PH_RESET;
        end else begin
            phase_r <= (phase_r == 2'(PHASES - 1)) ? CEOD_PH_RESET : phase_r + 2'h1;
        end
    end

    assign ph_q1 = (phase_r == 2'h0);
    assign ph_q2 = (phase_r == 2'h1);
    assign ph_q3 = (phase_r == 2'h2);
    assign ph_q4 = (phase_r == 2'(PHASES - 1));
endmodule : ceod_phase_gen

/* File: src/ceod_file_addr.sv */
`timescale 1ns/100ps
module ceod_file_addr
    import ceod_pkg::*;
(
    input  wire logic [7:0]  file_sel,
    input  wire logic        access_bit,
    input  wire logic        ext_en,
    input  wire logic [3:0]  bank_select_reg,
    input  wire logic [11:0] third_pointer,
    output logic      [11:0] data_addr
);
    logic        use_indexed;
    logic [11:0] access_addr;

    // Indexed form only while the extension is on and the offset is low
    assign use_indexed = !access_bit && ext_en && (file_sel <= ILO_LIMIT);     // RULE_04
    // Access bank: low half is GPR page 0, upper half maps onto the SFR page
    assign access_addr = {file_sel[7] ? ACCESS_SFR_PAGE : ACCESS_LOW_PAGE, file_sel};
    assign data_addr   = use_indexed ? third_pointer + {4'h0, file_sel}     // RULE_04
                       : (access_bit ? {bank_select_reg, file_sel} : access_addr);     // RULE_03
endmodule : ceod_file_addr

/* File: src/ceod_core_decoder.sv */
`timescale 1ns/100ps
// Overview of operation
// RULE_01: The test-and-skip opcode 0110 011a ffff ffff turns the next fetched word into a no-op when f is zero.
// RULE_02: Test-and-skip lasts one cycle, two when skipping, three when the skipped word is a two-word instruction.
// RULE_03: A cleared access bit selects the access bank and a set one the bank named by the bank select register.
// RULE_04: With the access bit clear and the extension on, file offsets up to 5Fh are added to the third pointer.
// RULE_05: The xor-literal opcode xors W with an 8-bit literal into W and updates N and Z in one cycle.
// RULE_06: The xor-file opcode xors W with f, writes W or f by the d bit, and updates N and Z in one cycle.
// RULE_07: The extension is on by default and a configuration bit chosen at programming turns it on or off.
// RULE_08: The extension adds eight literal instructions on the pointers, and none of them touches status.
// RULE_09: Add and subtract pointer opcodes E8/E9 change the selected pointer by a 6-bit literal in one cycle.
// RULE_10: A pointer select of 11 updates the third pointer, then returns from top of stack over two cycles.
// RULE_11: Call through W takes two cycles, the second being a no-op while the new word is fetched.
// RULE_12: Indexed moves are two words and two cycles with source third pointer plus offset, absolute or indexed dest.
// RULE_13: Push-literal writes the literal at the third pointer address and then decrements it, in one cycle.
// RULE_14: Call through W pushes PC+2 and loads the program counter from the latches and W.
// RULE_15: An indexed-move source on an indirect register reads 00h and such an indexed destination makes a no-op.
// RULE_16: With the extension off the extended opcodes execute as no-ops and change nothing.
module ceod_core_decoder
    import ceod_pkg::*;
#(
    parameter int PTR_W = 12
)(
    input  wire logic             clock,
    input  wire logic             arst_n,
    input  wire logic [15:0]      instr_word,
    input  wire logic [20:0]      instr_addr,
    input  wire logic             extension_enable_cfg,
    input  wire logic [3:0]       bank_select_reg,
    input  wire logic [7:0]       pc_high_latch,
    input  wire logic [4:0]       pc_upper_latch,
    input  wire logic [20:0]      top_of_stack,
    input  wire logic [7:0]       mem_rd_data,
    output logic                  word_take_r,
    output logic                  discard_r,
    output logic                  claim_r,
    output logic                  extension_active_r,
    output logic [11:0]           mem_addr_r,
    output logic                  mem_rd_en_r,
    output logic                  mem_wr_en_r,
    output logic [7:0]            mem_wr_data_r,
    output logic [7:0]            working_register_r,
    output logic                  flag_neg_r,
    output logic                  flag_zero_r,
    output logic [PTR_W-1:0]      pointer0_r,
    output logic [PTR_W-1:0]      pointer1_r,
    output logic [PTR_W-1:0]      third_pointer_r,
    output logic                  pc_load_r,
    output logic [20:0]           pc_target_r,
    output logic                  stack_push_r,
    output logic [20:0]           stack_push_value_r,
    output logic                  stack_pop_r
);
    logic              ph_q1;
    logic              ph_q2;
    logic              ph_q3;
    logic              ph_q4;
    ceod_state_t       state_r;
    ceod_state_t       state_nxt;
    ceod_op_t          op_r;
    ceod_op_t          op_dec;
    logic [15:0]       ir_r;
    logic [15:0]       word2_r;
    logic [20:0]       pc_r;
    logic [7:0]        rd_data_r;
    logic              skip_two_r;
    logic              cfg_taken_r;
    logic [PTR_W-1:0]  ptr_r [3];

    // Quarter-cycle enables
    ceod_phase_gen #(
        .PHASES (CEOD_PHASES)
    ) u_phase (
        .clock  (clock),
        .arst_n (arst_n),
        .ph_q1  (ph_q1),
        .ph_q2  (ph_q2),
        .ph_q3  (ph_q3),
        .ph_q4  (ph_q4)
    );

    // Opcode decode of the word presented at Q1
    logic dec_test;
    logic dec_xor_lit;
    logic dec_xor_file;
    logic dec_add;
    logic dec_sub;
    logic dec_push;
    logic dec_move;
    logic dec_call;
    logic dec_ext;
    assign dec_test     = (instr_word[15:9] == OP_TEST_SKIP);     // RULE_01
    assign dec_xor_lit  = (instr_word[15:8] == OP_XOR_LIT);     // RULE_05
    assign dec_xor_file = (instr_word[15:10] == OP_XOR_FILE);     // RULE_06
    assign dec_add      = (instr_word[15:8] == OP_ADD_PTR);     // RULE_09
    assign dec_sub      = (instr_word[15:8] == OP_SUB_PTR);     // RULE_09
    assign dec_push     = (instr_word[15:8] == OP_PUSH_LIT);     // RULE_13
    assign dec_move     = (instr_word[15:8] == OP_INDEX_MOVE);     // RULE_12
    assign dec_call     = (instr_word == OP_CALL_WORK);     // RULE_11
    assign dec_ext      = dec_add | dec_sub | dec_push | dec_move | dec_call;     // RULE_08

    // Extended opcodes fall through to no-op while the extension is off
    assign op_dec = (dec_ext && !extension_active_r) ? OPC_NONE     // RULE_16
                  : dec_test     ? OPC_TEST_SKIP
                  : dec_xor_lit  ? OPC_XOR_LIT
                  : dec_xor_file ? OPC_XOR_FILE
                  : dec_add      ? OPC_ADD_PTR
                  : dec_sub      ? OPC_SUB_PTR
                  : dec_push     ? OPC_PUSH_LIT
                  : dec_move     ? OPC_MOVE
                  : dec_call     ? OPC_CALL_WORK
                  : OPC_NONE;

    // Field extraction from the held word
    logic [5:0]       lit6;
    logic [7:0]       lit8;
    logic [1:0]       ptr_sel;
    logic [1:0]       ptr_idx;
    logic             ret_form;
    logic [11:0]      file_addr;
    logic [11:0]      src_addr;
    logic [11:0]      dst_addr;
    logic             src_indirect;
    logic             dst_blocked;
    assign lit6     = ir_r[5:0];
    assign lit8     = ir_r[7:0];
    assign ptr_sel  = ir_r[7:6];
    assign ret_form = (ptr_sel == PTR_SEL_RETURN);     // RULE_10
    assign ptr_idx  = ret_form ? PTR_SEL_THIRD : ptr_sel;     // RULE_10

    ceod_file_addr u_file_addr (
        .file_sel        (ir_r[7:0]),
        .access_bit      (ir_r[8]),
        .ext_en          (extension_active_r),
        .bank_select_reg (bank_select_reg),
        .third_pointer   (ptr_r[2][11:0]),
        .data_addr       (file_addr)
    );

    // Indexed move addresses; the absolute form takes all 12 bits of word two
    assign src_addr     = ptr_r[2][11:0] + {5'h00, ir_r[6:0]};     // RULE_12
    assign dst_addr     = ir_r[7] ? ptr_r[2][11:0] + {5'h00, word2_r[6:0]} : word2_r[11:0];     // RULE_12
    assign src_indirect = ceod_is_indirect(src_addr);     // RULE_15
    assign dst_blocked  = ir_r[7] && ceod_is_indirect(dst_addr);     // RULE_15

    // Results computed for Q4
    logic [7:0]       xor_res;
    logic [PTR_W-1:0] ptr_arith;
    logic             is_move2;
    logic             do_read;
    logic             do_write;
    logic [11:0]      wr_addr;
    logic [7:0]       wr_data;
    logic [7:0]       rd_now;
    assign is_move2  = (state_r == ST_MOVE_WORD2);
    assign rd_now    = (is_move2 && src_indirect) ? 8'h00 : mem_rd_data;     // RULE_15
    assign xor_res   = working_register_r ^ ((op_r == OPC_XOR_LIT) ? lit8 : rd_now);     // RULE_05
    assign ptr_arith = (op_r == OPC_ADD_PTR) ? ptr_r[ptr_idx] + PTR_W'(lit6)
                                             : ptr_r[ptr_idx] - PTR_W'(lit6);     // RULE_09
    assign do_read   = (state_r == ST_EXEC && (op_r == OPC_TEST_SKIP || op_r == OPC_XOR_FILE))
                    || (is_move2 && !src_indirect);     // RULE_15
    assign do_write  = (state_r == ST_EXEC && op_r == OPC_PUSH_LIT)
                    || (state_r == ST_EXEC && op_r == OPC_XOR_FILE && ir_r[9])
                    || (is_move2 && !dst_blocked);     // RULE_15
    assign wr_addr   = (op_r == OPC_PUSH_LIT) ? ptr_r[2][11:0]     // RULE_13
                     : (op_r == OPC_XOR_FILE) ? file_addr : dst_addr;
    assign wr_data   = (op_r == OPC_PUSH_LIT) ? lit8 : (op_r == OPC_XOR_FILE) ? xor_res : rd_now;

    // Cycle sequencing; each state is one instruction cycle
    always_comb begin
        state_nxt = ST_EXEC;
        case (state_r)
            ST_EXEC: begin
                case (op_r)
                    OPC_TEST_SKIP: state_nxt = (rd_data_r == 8'h00) ? ST_SKIP_NOP : ST_EXEC;     // RULE_01
                    OPC_ADD_PTR,
                    OPC_SUB_PTR:   state_nxt = ret_form ? ST_LAST_NOP : ST_EXEC;     // RULE_10
                    OPC_CALL_WORK: state_nxt = ST_LAST_NOP;     // RULE_11
                    OPC_MOVE:      state_nxt = ST_MOVE_WORD2;     // RULE_12
                    default:       state_nxt = ST_EXEC;
                endcase
            end
            ST_SKIP_NOP: state_nxt = skip_two_r ? ST_SKIP_NOP2 : ST_EXEC;     // RULE_02
            default:     state_nxt = ST_EXEC;
        endcase
    end

    // Configuration bit is taken once, on the first edge after reset release
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            extension_active_r <= EXT_EN_RESET;     // RULE_07
            cfg_taken_r        <= 1'b0;
        end else if (!cfg_taken_r) begin
            extension_active_r <= extension_enable_cfg;     // RULE_07
            cfg_taken_r        <= 1'b1;
        end
    end

    // Q1: take the fetched word and mark how this cycle treats it
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_r     <= ST_EXEC;
            op_r        <= OPC_NONE;
            ir_r        <= 16'h0000;
            word2_r     <= 16'h0000;
            pc_r        <= 21'h000000;
            skip_two_r  <= 1'b0;
            discard_r   <= 1'b0;
            claim_r     <= 1'b0;
            word_take_r <= 1'b1;
        end else begin
            word_take_r <= ph_q4;     // High during the Q1 clock that samples the word
            if (ph_q4) begin
                state_r <= state_nxt;
            end
            if (ph_q1) begin
                discard_r <= (state_r == ST_SKIP_NOP) || (state_r == ST_SKIP_NOP2) || (state_r == ST_LAST_NOP);     // RULE_02
                claim_r   <= (state_r == ST_MOVE_WORD2) || ((state_r == ST_EXEC) && (op_dec != OPC_NONE));
                if (state_r == ST_EXEC) begin
                    op_r <= op_dec;
                    ir_r <= instr_word;
                    pc_r <= instr_addr;
                end else if (state_r == ST_MOVE_WORD2) begin
                    word2_r <= instr_word;     // RULE_12
                end else begin
                    op_r <= OPC_NONE;     // RULE_01
                end
                skip_two_r <= (state_r == ST_SKIP_NOP) && ceod_is_two_word(instr_word);     // RULE_02
            end
        end
    end

    // Q2 read, Q3 capture, Q4 write; the write strobe lasts one clock, the read strobe three clocks until Q1
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            mem_addr_r    <= 12'h000;
            mem_rd_en_r   <= 1'b0;
            mem_wr_en_r   <= 1'b0;
            mem_wr_data_r <= 8'h00;
            rd_data_r     <= 8'h00;
        end else begin
            mem_rd_en_r <= ph_q1 ? 1'b0 : (ph_q2 ? 1'b0 : mem_rd_en_r);
            mem_wr_en_r <= 1'b0;
            if (ph_q2 && do_read) begin
                mem_addr_r  <= is_move2 ? src_addr : file_addr;
                mem_rd_en_r <= 1'b1;
            end
            if (ph_q3) begin
                rd_data_r <= rd_now;
            end
            if (ph_q3 && do_write) begin
                mem_addr_r    <= wr_addr;
                mem_wr_data_r <= wr_data;
                mem_wr_en_r   <= 1'b1;     // RULE_13
            end
        end
    end

    // Q4: working register, flags and pointers
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            working_register_r <= WORK_RESET;
            flag_neg_r         <= 1'b0;
            flag_zero_r        <= 1'b0;
            for (int i = 0; i < 3; i++) begin
                ptr_r[i] <= PTR_W'(PTR_RESET);
            end
        end else if (ph_q4 && state_r == ST_EXEC) begin
            if (op_r == OPC_XOR_LIT || op_r == OPC_XOR_FILE) begin
                if (op_r == OPC_XOR_LIT || !ir_r[9]) begin
                    working_register_r <= xor_res;     // RULE_06
                end
                flag_neg_r  <= xor_res[7];     // RULE_05
                flag_zero_r <= (xor_res == 8'h00);     // RULE_06
            end
            if (op_r == OPC_ADD_PTR || op_r == OPC_SUB_PTR) begin
                ptr_r[ptr_idx] <= ptr_arith;     // RULE_09
            end
            if (op_r == OPC_PUSH_LIT) begin
                ptr_r[2] <= ptr_r[2] - PTR_W'(1);     // RULE_13
            end
        end
    end

    // Program counter and return stack requests, one clock at Q4
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pc_load_r          <= 1'b0;
            pc_target_r        <= 21'h000000;
            stack_push_r       <= 1'b0;
            stack_push_value_r <= 21'h000000;
            stack_pop_r        <= 1'b0;
        end else begin
            pc_load_r    <= 1'b0;
            stack_push_r <= 1'b0;
            stack_pop_r  <= 1'b0;
            if (ph_q4 && state_r == ST_EXEC && (op_r == OPC_ADD_PTR || op_r == OPC_SUB_PTR) && ret_form) begin
                pc_load_r   <= 1'b1;     // RULE_10
                pc_target_r <= top_of_stack;
                stack_pop_r <= 1'b1;
            end
            if (ph_q4 && state_r == ST_EXEC && op_r == OPC_CALL_WORK) begin
                stack_push_r       <= 1'b1;     // RULE_14
                stack_push_value_r <= pc_r + RETURN_STEP;
                pc_load_r          <= 1'b1;
                pc_target_r        <= {pc_upper_latch, pc_high_latch, working_register_r};     // RULE_14
            end
        end
    end

    assign pointer0_r      = ptr_r[0];
    assign pointer1_r      = ptr_r[1];
    assign third_pointer_r = ptr_r[2];
endmodule : ceod_core_decoder

/* File: sim/ceod_core_decoder_monitor.sv */
`timescale 1ns/100ps
module ceod_core_monitor #(
    parameter int PTR_W = 12
)(
    input wire logic             clock,
    input wire logic             arst_n,
    input wire logic [15:0]      instr_word,
    input wire logic [20:0]      top_of_stack,
    input wire logic             word_take_r,
    input wire logic             discard_r,
    input wire logic             claim_r,
    input wire logic             extension_active_r,
    input wire logic             mem_wr_en_r,
    input wire logic [7:0]       working_register_r,
    input wire logic             flag_neg_r,
    input wire logic             flag_zero_r,
    input wire logic [PTR_W-1:0] third_pointer_r,
    input wire logic             pc_load_r,
    input wire logic [20:0]      pc_target_r,
    input wire logic             stack_push_r,
    input wire logic             stack_pop_r
);
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);

    // Cycle framing and the timing of program counter pulses
    a_cycle_four_clocks : assert property (
        word_take_r |=> !word_take_r [*3] ##1 word_take_r) else $error("instruction cycle is not four clocks");
    a_pulse_in_fetch : assert property (
        (pc_load_r || stack_push_r || stack_pop_r) |-> word_take_r) else $error("flow pulse outside fetch clock");
    a_call_loads_pc : assert property (
        stack_push_r |-> pc_load_r && !stack_pop_r) else $error("push without program counter load");
    a_return_target : assert property (
        stack_pop_r |-> pc_load_r && pc_target_r == top_of_stack) else $error("return target wrong");
    // Writes are single clocks and never happen in a discarded cycle
    a_write_one_clock : assert property (
        mem_wr_en_r |=> !mem_wr_en_r) else $error("write strobe longer than a clock");
    a_discard_no_write : assert property (
        discard_r |-> !mem_wr_en_r) else $error("write during discarded cycle");
    // With the extension off its opcodes are refused and the third pointer holds
    a_ext_off_refused : assert property (
        !extension_active_r && word_take_r && (instr_word[15:10] == 6'h3A || instr_word == 16'h0014)
        |=> !claim_r) else $error("extended opcode claimed while disabled");
    a_ext_off_hold : assert property (
        !extension_active_r |-> $stable(third_pointer_r)) else $error("pointer moved while disabled");
    // Flags only move at the end of a cycle and must agree with a new W
    a_flags_at_fetch : assert property (
        ($changed(flag_zero_r) || $changed(flag_neg_r)) |-> word_take_r) else $error("flags changed mid cycle");
    a_work_flags_agree : assert property (
        $changed(working_register_r) |-> flag_zero_r == (working_register_r == 8'h00)
        && flag_neg_r == working_register_r[7]) else $error("flags disagree with W");

    c_return : cover property (stack_pop_r);
    c_call : cover property (stack_push_r);
    c_long_skip : cover property (discard_r ##4 discard_r);
endmodule : ceod_core_monitor

bind ceod_core_decoder ceod_core_monitor #(.PTR_W(PTR_W)) i_ceod_core_monitor (.*);

/* File: sim/ceod_data_mem_model.sv */
`timescale 1ns/100ps
module ceod_data_mem_model (
    input  wire logic        clock,
    input  wire logic [11:0] mem_addr,
    input  wire logic        rd_en,
    input  wire logic        wr_en,
    input  wire logic [7:0]  wr_data,
    output logic      [7:0]  rd_data
);
    logic [7:0] mem [0:4095];
    logic [7:0] junk_r = 8'h5A;

    initial for (int a = 0; a < 4096; a++) mem[a] = 8'h00;
    // Unselected reads show a toggling pattern so stale data never looks valid
    assign rd_data = rd_en ? mem[mem_addr] : junk_r;
    // Plain always so the bench may preload cells
    always @(posedge clock) begin
        junk_r <= ~junk_r;
        if (wr_en) mem[mem_addr] <= wr_data;
    end
endmodule : ceod_data_mem_model

/* File: sim/ceod_core_decoder_tb.sv */
`timescale 1ns/100ps
module ceod_core_decoder_tb;
    logic        clock, arst_n, extension_enable_cfg, word_take_r, discard_r, claim_r, extension_active_r;
    logic        mem_rd_en_r, mem_wr_en_r, flag_neg_r, flag_zero_r, pc_load_r, stack_push_r, stack_pop_r, hit;
    logic [3:0]  bank_select_reg;
    logic [4:0]  pc_upper_latch;
    logic [7:0]  pc_high_latch, mem_rd_data, mem_wr_data_r, working_register_r;
    logic [11:0] mem_addr_r, pointer0_r, pointer1_r, third_pointer_r;
    logic [15:0] instr_word;
    logic [20:0] instr_addr, top_of_stack, pc_target_r, stack_push_value_r, pc, tgt, pushed, call_at;
    int          fail_count, compares;

    ceod_core_decoder i_ceod_core_decoder (.*);
    ceod_data_mem_model i_mem (.clock(clock), .mem_addr(mem_addr_r), .rd_en(mem_rd_en_r), .wr_en(mem_wr_en_r),
        .wr_data(mem_wr_data_r), .rd_data(mem_rd_data));

    initial begin
        clock = 1'h0;
        forever #5 clock = ~clock;
    end
    // Pulses last one clock, so latch them for checks made later
    always @(posedge clock) begin
        if (pc_load_r === 1'h1) begin
            hit = 1'h1;
            tgt = pc_target_r;
            pushed = stack_push_r ? stack_push_value_r : 21'h0;
        end
    end

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask : chk
    task automatic do_reset(input logic cfg);
        arst_n = 1'h0;
        extension_enable_cfg = cfg;
        repeat (10) @(negedge clock);
        arst_n = 1'h1;
    endtask : do_reset
    // Present a word in the fetch clock; results of the previous cycle are settled then
    task automatic issue(input logic [15:0] w);
        int n;
        n = 0;
        @(negedge clock);
        while (word_take_r !== 1'h1 && n < 8) begin
            n++;
            @(negedge clock);
        end
        if (n >= 8) begin
            fail_count++;
            give_verdict();
        end
        instr_word = w;
        instr_addr = pc;
        pc = pc + 21'h2;
    endtask : issue
    task automatic give_verdict();
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : give_verdict

    initial begin
        fail_count = 0; compares = 0; pc = 21'h0; hit = 1'h0; instr_word = 16'h0; instr_addr = 21'h0;
        bank_select_reg = 4'h2; pc_high_latch = 8'h12; pc_upper_latch = 5'h03; top_of_stack = 21'h0ABCDE;
        do_reset(1'h1);
        i_mem.mem[12'h290] = 8'hAF;
        i_mem.mem[12'hF90] = 8'h0F;
        i_mem.mem[12'h028] = 8'h5D;
        chk(24'(extension_active_r), 24'h1);
        issue(16'h0AB5);
        issue(16'h0AB5);
        chk({14'h0, flag_neg_r, flag_zero_r, working_register_r}, 24'h2B5);
        issue(16'h0AB5);
        chk({14'h0, flag_neg_r, flag_zero_r, working_register_r}, 24'h100);
        issue(16'h1B90);
        issue(16'h1990);
        chk(24'(i_mem.mem[12'h290]), 24'h1A);
        chk({14'h0, flag_neg_r, flag_zero_r, working_register_r}, 24'h0B5);
        issue(16'h1A90);
        chk({14'h0, flag_neg_r, flag_zero_r, working_register_r}, 24'h2AF);
        issue(16'hE8A3);
        chk(24'(i_mem.mem[12'hF90]), 24'hA0);
        $display("test xor_and_banking done");
        issue(16'hE901);
        chk(24'(third_pointer_r), 24'h023);
        issue(16'hE87F);
        chk(24'(pointer0_r), 24'hFFF);
        issue(16'hEA08);
        chk(24'(pointer1_r), 24'h03F);
        issue(16'h0000);
        chk({third_pointer_r, 4'h0, i_mem.mem[12'h023]}, 24'h022008);
        chk({22'h0, flag_neg_r, flag_zero_r}, 24'h2);
        $display("test pointers done");
        issue(16'h6605);
        issue(16'hC123);
        chk(24'(discard_r), 24'h0);
        issue(16'hF456);
        chk(24'(discard_r), 24'h1);
        issue(16'h0000);
        chk(24'(discard_r), 24'h1);
        issue(16'h6790);
        chk(24'(discard_r), 24'h0);
        issue(16'h0AFF);
        issue(16'h6605);
        chk({discard_r, 15'h0, working_register_r}, 24'h000050);
        issue(16'h0A0F);
        issue(16'h0000);
        chk({discard_r, 15'h0, working_register_r}, 24'h800050);
        issue(16'h0000);
        chk(24'(discard_r), 24'h0);
        $display("test skip done");
        for (int i = 0; i < 2; i++) begin
            hit = 1'h0;
            issue(i == 0 ? 16'hE8C1 : 16'hE9C1);
            issue(16'h0000);
            issue(16'h0000);
            chk(24'(discard_r), 24'h1);
            @(posedge clock);
            chk({2'h0, hit, tgt}, {3'h1, top_of_stack});
            chk(24'(third_pointer_r), i == 0 ? 24'h023 : 24'h022);
        end
        hit = 1'h0;
        call_at = pc;
        issue(16'h0014);
        issue(16'h0000);
        issue(16'h0000);
        chk(24'(discard_r), 24'h1);
        @(posedge clock);
        chk({2'h0, hit, tgt}, 24'h231250);
        chk({3'h0, pushed}, {3'h0, call_at + 21'h2});
        $display("test return_and_call done");
        i_mem.mem[12'h027] = 8'h3C;
        issue(16'hEB05);
        issue(16'hF300);
        issue(16'h0000);
        chk(24'(claim_r), 24'h1);
        issue(16'hEB86);
        chk(24'(i_mem.mem[12'h300]), 24'h3C);
        issue(16'hF007);
        issue(16'h0000);
        issue(16'h0000);
        chk(24'(i_mem.mem[12'h029]), 24'h5D);
        $display("test moves done");
        do_reset(1'h0);
        hit = 1'h0;
        issue(16'hE8A3);
        chk(24'(extension_active_r), 24'h0);
        issue(16'hEA08);
        issue(16'h0014);
        chk(24'(claim_r), 24'h0);
        issue(16'h0000);
        issue(16'h0000);
        @(posedge clock);
        chk({hit, third_pointer_r, i_mem.mem[12'h000]}, 21'h0);
        $display("test extension_off done");
        give_verdict();
    end
endmodule : ceod_core_decoder_tb
